/* File: verilog/vir_cfg.svh */
// register offsets, field positions, reset values and fixed bytes of the interrupt responder
// assumes an AXI4-Lite slave decoding byte addresses in the low eight bits
`ifndef VIR_CFG_SVH
`define VIR_CFG_SVH
`define VIR_OFS_CTRL 8'h00
`define VIR_OFS_VEC 8'h04
`define VIR_OFS_VSTAT 8'h08
`define VIR_OFS_CMD 8'h0C
`define VIR_OFS_STAT 8'h10
`define VIR_OFS_MASK 8'h14
`define VIR_OFS_SVC 8'h18
`define VIR_BIT_SAV 0
`define VIR_BIT_MODE2 3
`define VIR_BIT_HOST16 4
`define VIR_BIT_VEC_EN 5
`define VIR_RST_CTRL 8'h00
`define VIR_RST_VEC 8'h00
`define VIR_RST_MASK 8'h00
`define VIR_RST_PEND 8'h00
`define VIR_CALL_BYTE 8'hCD
`define VIR_TRAIL_BYTE 8'h00
`define VIR_EOI_CMD 8'h38
`define VIR_RESP_OKAY 2'h0
`define VIR_RESP_SLVERR 2'h2
`endif

/* File: verilog/vir_pkg.sv */
// types and shared vector arithmetic of the interrupt responder
// assumes vir_cfg.svh holds the field positions
`include "vir_cfg.svh"
package vir_pkg;
	typedef enum logic [2:0] {VIR_H_MODE1 = 3'b001, VIR_H_MODE2 = 3'b010, VIR_H_16 = 3'b100} vir_host_t;
	typedef enum logic [2:0] {VIR_ST_WAIT1 = 3'b001, VIR_ST_WAIT2 = 3'b010, VIR_ST_WAIT3 = 3'b100} vir_ack_t;

	function automatic vir_host_t vir_host_of(input logic [7:0] ctrl);
		if (ctrl[`VIR_BIT_HOST16])
			return VIR_H_16;
		else if (ctrl[`VIR_BIT_MODE2])
			return VIR_H_MODE2;
		else
			return VIR_H_MODE1;
	endfunction

	// source code lands in bits 4:2 for byte hosts, 2:0 for the word host
	function automatic logic [7:0] vir_mod_vector(input logic [7:0] vec, input logic [2:0] code,
		input logic host16, input logic sav);
		logic [7:0] v;
		v = vec;
		if (sav && host16)
			v[2:0] = code;
		else if (sav)
			v[4:2] = code;
		return v;
	endfunction
endpackage

/* File: verilog/vir_sync2.sv */
// two-stage synchroniser for one pin level
// assumes the pin is asynchronous to aclk; reset value is the idle (high) level
`timescale 1ns/1ps
module vir_sync2 (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin_in,
	output logic level_out
);
	logic meta_ff;
	logic sync_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
		end
		else
		begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
		end
	end

	assign level_out = sync_ff;
endmodule

/* File: verilog/vir_src_encode.sv */
// picks the highest pending source; index 7 (channel a special receive) wins
// assumes pending bits indexed by their three-bit source code
`timescale 1ns/1ps
module vir_src_encode (
	input wire logic [7:0] pending,
	output logic any,
	output logic [2:0] code
);
	always_comb
	begin
		any = |pending;
		code = 3'h0;
		for (int i = 0; i < 8; i++)
		begin
			if (pending[i])
				code = 3'(i);
		end
	end
endmodule

/* File: verilog/vir_top.sv */
// vectored interrupt responder: source latching, acknowledge protocol, daisy chain, AXI4-Lite registers
// assumes event inputs are one-cycle pulses on aclk; acknowledge and priority pins are asynchronous
//
// Notes on behaviour
// - vector enable clear keeps bus floating always
// - mode1 gives CD, vector, 00; others vector only
// - vector byte only while priority chain active
// - source code replaces bits 4:2 or 2:0
// - channel a codes 100, 101, 110, 111
// - parity, framing/crc, overrun, frame end raise special
// - cts, carrier, sync, message end, break raise status
// - vector status read shows modified vector only with status-affects-vector set
// - lower priorities held off until end command
// - first received character interrupts even under dma
`timescale 1ns/1ps
`include "vir_cfg.svh"
module vir_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cha_tx_empty,
	input wire logic [4:0] cha_ext_src,
	input wire logic cha_rx_char,
	input wire logic cha_rx_first,
	input wire logic [3:0] cha_special_src,
	input wire logic chb_tx_empty,
	input wire logic [4:0] chb_ext_src,
	input wire logic chb_rx_char,
	input wire logic chb_rx_first,
	input wire logic [3:0] chb_special_src,
	input wire logic interrupt_acknowledge_n,
	input wire logic priority_chain_in_n,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic priority_chain_out_n,
	output logic host_int_n,
	output logic irq
);
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic aw_held_ff, w_held_ff, wstrb0_ff;
	logic [31:0] awaddr_ff;
	logic [7:0] wdata_ff;
	logic [7:0] ctrl_ff, vec_ff, mask_ff, pend_ff;
	logic svc_active_ff;
	logic [2:0] svc_code_ff, ack_code_ff;
	logic irq_ff, host_int_n_ff, chain_out_n_ff;
	logic [7:0] data_out_ff;
	logic data_oe_ff;
	logic [1:0] drv_cyc_ff;
	logic ack_d_ff;
	vir_pkg::vir_ack_t st_ff;
	logic ack_s, chain_in_s;
	logic enc_any;
	logic [2:0] enc_code;
	logic wr_fire, ack_fall, ack_rise, host_req, vstat_read, svc_set, eoi_wr, sav, host16, vec_en;
	logic chain_act, stat_clr;
	logic [7:0] events;
	logic [7:0] nxt_pend;
	vir_pkg::vir_host_t host_mode;

	function automatic logic wr_hit(input logic [7:0] ofs);
		return wr_fire && wstrb0_ff && awaddr_ff[31:8] == 24'h000000 && awaddr_ff[7:0] == ofs;
	endfunction

	function automatic logic addr_ok(input logic [31:0] a);
		return a[31:8] == 24'h000000 && (a[7:0] == `VIR_OFS_CTRL || a[7:0] == `VIR_OFS_VEC
			|| a[7:0] == `VIR_OFS_VSTAT || a[7:0] == `VIR_OFS_CMD || a[7:0] == `VIR_OFS_STAT
			|| a[7:0] == `VIR_OFS_MASK || a[7:0] == `VIR_OFS_SVC);
	endfunction

	vir_sync2 u_sync_ack (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(interrupt_acknowledge_n),
		.level_out(ack_s)
	);

	vir_sync2 u_sync_chain (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(priority_chain_in_n),
		.level_out(chain_in_s)
	);

	vir_src_encode u_enc (
		.pending(pend_ff),
		.any(enc_any),
		.code(enc_code)
	);

	assign sav = ctrl_ff[`VIR_BIT_SAV];
	assign vec_en = ctrl_ff[`VIR_BIT_VEC_EN];
	assign host_mode = vir_pkg::vir_host_of(ctrl_ff);
	assign host16 = host_mode == vir_pkg::VIR_H_16;
	assign chain_act = !chain_in_s;
	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	assign ack_fall = ack_d_ff && !ack_s;
	assign ack_rise = !ack_d_ff && ack_s;
	// wr_hit reads module state, so a plain assign would never re-evaluate it
	always_comb
	begin
		eoi_wr = wr_hit(`VIR_OFS_CMD) && wdata_ff == `VIR_EOI_CMD;
		stat_clr = wr_hit(`VIR_OFS_STAT);
	end
	assign vstat_read = s_axi_arvalid && arready_ff && s_axi_araddr[31:0] == {24'h000000, `VIR_OFS_VSTAT};
	// source slots follow the status-affects-vector code: b first, then a
	assign events = {|cha_special_src, cha_rx_char | cha_rx_first, |cha_ext_src, cha_tx_empty,
		|chb_special_src, chb_rx_char | chb_rx_first, |chb_ext_src, chb_tx_empty};
	// only a higher source may break through an interrupt in service
	assign host_req = enc_any && (!svc_active_ff || enc_code > svc_code_ff);
	assign svc_set = (ack_fall && st_ff == vir_pkg::VIR_ST_WAIT2 && vec_en && chain_act)
		|| (vstat_read && enc_any);

	// write channel: address and data may arrive in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= 32'h00000000;
			wdata_ff <= 8'h00;
			wstrb0_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `VIR_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && awready_ff)
			begin
				aw_held_ff <= 1'b1;
				awready_ff <= 1'b0;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_ff)
			begin
				w_held_ff <= 1'b1;
				wready_ff <= 1'b0;
				wdata_ff <= s_axi_wdata[7:0];
				wstrb0_ff <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= addr_ok(awaddr_ff) ? `VIR_RESP_OKAY : `VIR_RESP_SLVERR;
			end
			if (bvalid_ff && s_axi_bready)
			begin
				bvalid_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	// read channel: one read in flight, answered on the next edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `VIR_RESP_OKAY;
		end
		else if (s_axi_arvalid && arready_ff)
		begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rresp_ff <= addr_ok(s_axi_araddr) ? `VIR_RESP_OKAY : `VIR_RESP_SLVERR;
			rdata_ff <= 32'h00000000;
			if (s_axi_araddr[31:8] == 24'h000000)
			begin
				unique case (s_axi_araddr[7:0])
					`VIR_OFS_CTRL: rdata_ff[7:0] <= ctrl_ff;
					`VIR_OFS_VEC: rdata_ff[7:0] <= vec_ff;
					`VIR_OFS_VSTAT: rdata_ff[7:0] <= vir_pkg::vir_mod_vector(vec_ff, enc_code, host16, sav);
					`VIR_OFS_STAT: rdata_ff[7:0] <= pend_ff;
					`VIR_OFS_MASK: rdata_ff[7:0] <= mask_ff;
					`VIR_OFS_SVC: rdata_ff[7:0] <= {4'h0, svc_active_ff, svc_code_ff};
					default: rdata_ff <= 32'h00000000;
				endcase
			end
		end
		else if (rvalid_ff && s_axi_rready)
		begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_ff <= `VIR_RST_CTRL;
			vec_ff <= `VIR_RST_VEC;
			mask_ff <= `VIR_RST_MASK;
		end
		else
		begin
			if (wr_hit(`VIR_OFS_CTRL))
				ctrl_ff <= wdata_ff;
			if (wr_hit(`VIR_OFS_VEC))
				vec_ff <= wdata_ff;
			if (wr_hit(`VIR_OFS_MASK))
				mask_ff <= wdata_ff;
		end
	end

	// sticky sources; an event in the clearing cycle survives
	always_comb
	begin
		nxt_pend = pend_ff;
		if (stat_clr)
			nxt_pend = nxt_pend & ~wdata_ff;
		nxt_pend = nxt_pend | events;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pend_ff <= `VIR_RST_PEND;
			irq_ff <= 1'b0;
		end
		else
		begin
			pend_ff <= nxt_pend;
			irq_ff <= |(pend_ff & mask_ff);
		end
	end

	// in-service marker; a service that lands with the end command wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			svc_active_ff <= 1'b0;
			svc_code_ff <= 3'h0;
		end
		else if (svc_set)
		begin
			svc_active_ff <= 1'b1;
			svc_code_ff <= vstat_read ? enc_code : ack_code_ff;
		end
		else if (eoi_wr)
			svc_active_ff <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			host_int_n_ff <= 1'b1;
			chain_out_n_ff <= 1'b1;
		end
		else
		begin
			host_int_n_ff <= !host_req;
			// a requesting or serviced device holds lower devices off the chain
			chain_out_n_ff <= chain_in_s || host_req || svc_active_ff;
		end
	end

	// acknowledge sequencer: the code is frozen at the first pulse so the vector cannot shift mid-sequence
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ack_d_ff <= 1'b1;
			st_ff <= vir_pkg::VIR_ST_WAIT1;
			ack_code_ff <= 3'h0;
			data_out_ff <= 8'h00;
			data_oe_ff <= 1'b0;
			drv_cyc_ff <= 2'h0;
		end
		else
		begin
			ack_d_ff <= ack_s;
			if (ack_fall)
			begin
				data_oe_ff <= 1'b0;
				unique case (st_ff)
					vir_pkg::VIR_ST_WAIT1:
					begin
						ack_code_ff <= enc_code;
						drv_cyc_ff <= 2'h1;
						if (vec_en && host_mode == vir_pkg::VIR_H_MODE1)
						begin
							data_out_ff <= `VIR_CALL_BYTE;
							data_oe_ff <= 1'b1;
						end
					end
					vir_pkg::VIR_ST_WAIT2:
					begin
						drv_cyc_ff <= 2'h2;
						if (vec_en && chain_act)
						begin
							data_out_ff <= vir_pkg::vir_mod_vector(vec_ff, ack_code_ff, host16, sav);
							data_oe_ff <= 1'b1;
						end
					end
					vir_pkg::VIR_ST_WAIT3:
					begin
						drv_cyc_ff <= 2'h3;
						if (vec_en && host_mode == vir_pkg::VIR_H_MODE1)
						begin
							data_out_ff <= `VIR_TRAIL_BYTE;
							data_oe_ff <= 1'b1;
						end
					end
				endcase
			end
			else if (ack_rise)
			begin
				data_oe_ff <= 1'b0;
				unique case (st_ff)
					vir_pkg::VIR_ST_WAIT1: st_ff <= vir_pkg::VIR_ST_WAIT2;
					vir_pkg::VIR_ST_WAIT2: st_ff <= host16 ? vir_pkg::VIR_ST_WAIT1 : vir_pkg::VIR_ST_WAIT3;
					vir_pkg::VIR_ST_WAIT3: st_ff <= vir_pkg::VIR_ST_WAIT1;
				endcase
			end
			// dropping the enable mid-pulse releases the bus at once
			if (!vec_en)
				data_oe_ff <= 1'b0;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign data_out = data_out_ff;
	assign data_oe = data_oe_ff;
	assign priority_chain_out_n = chain_out_n_ff;
	assign host_int_n = host_int_n_ff;
	assign irq = irq_ff;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_nonvec_float;
		!vec_en |=> !data_oe_ff;
	endproperty
	a_nonvec_float: assert property (p_nonvec_float) else $error("bus driven in non-vectored mode");

	property p_call_trail;
		data_oe_ff |-> (drv_cyc_ff == 2'h1 && data_out_ff == `VIR_CALL_BYTE) || drv_cyc_ff == 2'h2
			|| (drv_cyc_ff == 2'h3 && data_out_ff == `VIR_TRAIL_BYTE);
	endproperty
	a_call_trail: assert property (p_call_trail) else $error("wrong byte in acknowledge cycle");

	property p_vec_gate;
		$rose(data_oe_ff) && drv_cyc_ff == 2'h2 |-> $past(chain_act);
	endproperty
	a_vec_gate: assert property (p_vec_gate) else $error("vector driven with chain inactive");

	property p_sav_byte;
		data_oe_ff && drv_cyc_ff == 2'h2 && sav && !host16 |-> data_out_ff[4:2] == ack_code_ff;
	endproperty
	a_sav_byte: assert property (p_sav_byte) else $error("source code missing from vector");

	property p_cha_codes;
		pend_ff[7:5] == 3'b001 |-> enc_code == 3'b101;
	endproperty
	a_cha_codes: assert property (p_cha_codes) else $error("channel a status code wrong");

	property p_special;
		|cha_special_src |=> pend_ff[7] ##1 pend_ff[7] || $past(stat_clr);
	endproperty
	a_special: assert property (p_special) else $error("special receive not latched");

	property p_ext;
		|chb_ext_src |=> pend_ff[1];
	endproperty
	a_ext: assert property (p_ext) else $error("status change not latched");

	property p_vstat;
		vstat_read && sav && !host16 |=> rdata_ff[4:2] == $past(enc_code);
	endproperty
	a_vstat: assert property (p_vstat) else $error("vector status not modified");

	property p_block;
		svc_active_ff && enc_code <= svc_code_ff |=> host_int_n_ff;
	endproperty
	a_block: assert property (p_block) else $error("lower interrupt passed while in service");

	property p_first_char;
		cha_rx_first |=> pend_ff[6];
	endproperty
	a_first_char: assert property (p_first_char) else $error("first character not raised");

	property p_plain_vec;
		data_oe_ff && drv_cyc_ff == 2'h2 && !sav |-> data_out_ff == vec_ff;
	endproperty
	a_plain_vec: assert property (p_plain_vec) else $error("vector altered without status bits");

	c_call: cover property (data_oe_ff && data_out_ff == `VIR_CALL_BYTE);
	c_vector: cover property (data_oe_ff && drv_cyc_ff == 2'h2 && sav);
	c_eoi: cover property (svc_active_ff ##1 eoi_wr);
	c_irq: cover property ($rose(irq_ff));
endmodule

/* File: tb/vir_host_model.sv */
// host-side partner of vir_top: acknowledge pulses and the priority chain input
// assumes aclk at 4 ns; pin phases are long against the two-flop synchronisers
`timescale 1ns/1ps
module vir_host_model (
	input wire logic aclk,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	output logic ack_n,
	output logic chain_n
);
	initial
	begin
		ack_n = 1'b1;
		chain_n = 1'b0;
	end

	// six clocks per phase covers the 3 +/- 1 clock answer and release latency
	task automatic ack(output logic [8:0] seen);
		@(posedge aclk);
		ack_n <= 1'b0;
		repeat (6) @(posedge aclk);
		seen = {data_oe, data_oe ? data_out : 8'h00};
		ack_n <= 1'b1;
		repeat (6) @(posedge aclk);
	endtask

	task automatic chain(input logic v);
		@(posedge aclk);
		chain_n <= v;
		repeat (4) @(posedge aclk);
	endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for vir_top: register access, source coding, acknowledge protocols
// assumes the host model drives the acknowledge and chain pins
`timescale 1ns/1ps
`include "vir_cfg.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rr;
	logic [23:0] ev = '0;
	logic [7:0] data_out;
	logic data_oe, cout_n, host_int_n, irq, ack_n, chain_n;
	int error_cnt = 0;
	int comparisons = 0;

	always #2 aclk = ~aclk;

	vir_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.chb_tx_empty(ev[0]), .chb_ext_src(ev[5:1]), .chb_rx_char(ev[6]), .chb_rx_first(ev[7]),
		.chb_special_src(ev[11:8]), .cha_tx_empty(ev[12]), .cha_ext_src(ev[17:13]), .cha_rx_char(ev[18]),
		.cha_rx_first(ev[19]), .cha_special_src(ev[23:20]), .interrupt_acknowledge_n(ack_n),
		.priority_chain_in_n(chain_n), .data_out(data_out), .data_oe(data_oe),
		.priority_chain_out_n(cout_n), .host_int_n(host_int_n), .irq(irq));

	vir_host_model host (.aclk(aclk), .data_out(data_out), .data_oe(data_oe), .ack_n(ack_n), .chain_n(chain_n));

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		`CHK({bvalid, bresp}, {1'b1, er})
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 50);
		`CHK(rvalid, 1'b1)
		d = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask

	// event position in ev: channel b low half, then tx, five status, rx, first, four special
	task automatic fire(input int c, input int s);
		@(posedge aclk);
		ev <= 24'h1 << ((c > 3 ? 12 : 0) + (c % 4 == 0 ? 0 : c % 4 == 1 ? 1 + s : c % 4 == 2 ? 6 + s : 8 + s));
		@(posedge aclk);
		ev <= '0;
	endtask

	function automatic logic [7:0] xv(input logic [7:0] v, input logic [2:0] c, input logic h);
		return h ? {v[7:3], c} : {v[7:5], c, v[1:0]};
	endfunction

	task automatic summarize();
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#100000;
		error_cnt++;
		summarize();
	end

	initial
	begin
		logic [8:0] s, e;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a < 8'h1C; a += 4)
			chk_rd(a[7:0], 32'h0);
		chk_rd(8'h1C, 32'h0);
		`CHK(rr, `VIR_RESP_SLVERR)
		wr(8'h1C, 32'hFF, `VIR_RESP_SLVERR);
		wr(`VIR_OFS_VEC, 32'hA5, `VIR_RESP_OKAY);
		wstrb <= 4'h0;
		wr(`VIR_OFS_VEC, 32'h5A, `VIR_RESP_OKAY);
		wstrb <= 4'hF;
		wr(`VIR_OFS_VSTAT, 32'h33, `VIR_RESP_OKAY);
		chk_rd(`VIR_OFS_VSTAT, 32'hA5);
		`CHK({cout_n, host_int_n, irq, data_oe}, 4'b0100)
		$display("test 1 done: reset and access kinds");
		fire(6, 1);
		repeat (3) @(posedge aclk);
		`CHK(host_int_n, 1'b0)
		chk_rd(`VIR_OFS_VSTAT, 32'hA5);
		wr(`VIR_OFS_CTRL, 32'h01, `VIR_RESP_OKAY);
		chk_rd(`VIR_OFS_VSTAT, {24'h0, xv(8'hA5, 3'h6, 1'b0)});
		for (int p = 0; p < 3; p++)
		begin
			host.ack(s);
			`CHK(s, 9'h000)
		end
		wr(`VIR_OFS_STAT, 32'h40, `VIR_RESP_OKAY);
		fire(0, 0);
		repeat (3) @(posedge aclk);
		`CHK(host_int_n, 1'b1)
		wr(`VIR_OFS_CMD, `VIR_EOI_CMD, `VIR_RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK(host_int_n, 1'b0)
		wr(`VIR_OFS_MASK, 32'h01, `VIR_RESP_OKAY);
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'b1)
		wr(`VIR_OFS_MASK, 32'h00, `VIR_RESP_OKAY);
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'b0)
		wr(`VIR_OFS_MASK, 32'h01, `VIR_RESP_OKAY);
		wr(`VIR_OFS_STAT, 32'h01, `VIR_RESP_OKAY);
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'b0)
		wr(`VIR_OFS_MASK, 32'h00, `VIR_RESP_OKAY);
		$display("test 2 done: polled service and end command");
		for (int c = 0; c < 8; c++)
			for (int k = 0; k < (c % 4 == 0 ? 1 : c % 4 == 1 ? 5 : c % 4 == 2 ? 2 : 4); k++)
			begin
				fire(c, k);
				chk_rd(`VIR_OFS_STAT, 32'h1 << c);
				chk_rd(`VIR_OFS_VSTAT, {24'h0, xv(8'hA5, c[2:0], 1'b0)});
				wr(`VIR_OFS_STAT, 32'hFF, `VIR_RESP_OKAY);
				wr(`VIR_OFS_CMD, `VIR_EOI_CMD, `VIR_RESP_OKAY);
			end
		$display("test 3 done: source coding");
		fire(7, 0);
		for (int m = 0; m < 6; m++)
		begin
			host.chain(m > 2);
			wr(`VIR_OFS_CTRL, m % 3 == 0 ? 32'h21 : m == 1 ? 32'h28 : m % 3 == 1 ? 32'h29 : 32'h31, `VIR_RESP_OKAY);
			`CHK(cout_n, 1'b1)
			for (int p = 0; p < (m % 3 == 2 ? 2 : 3); p++)
			begin
				host.ack(s);
				e = 9'h000;
				if (p == 1 && m < 3)
					e = {1'b1, m == 1 ? 8'hA5 : xv(8'hA5, 3'h7, m % 3 == 2)};
				if (m % 3 == 0 && p != 1)
					e = p == 0 ? {1'b1, `VIR_CALL_BYTE} : {1'b1, `VIR_TRAIL_BYTE};
				`CHK(s, e)
			end
			wr(`VIR_OFS_CMD, `VIR_EOI_CMD, `VIR_RESP_OKAY);
		end
		$display("test 4 done: acknowledge protocols");
		summarize();
	end
endmodule
